/* hw/asw_ctrl.sv */
// host write controller for a byte-wide asynchronous static memory
// assumes the memory pins are driven directly; data wire resolved outside
// Operation
// - keep strobe high while address changes
// - never drive data while memory drives
// - data valid before terminating rise
// - data held past terminating rise
// - cycle time between address changes
// - address valid before starting fall
// - address valid before terminating rise
// - address held past terminating rise
// - strobe low pulse least width
// - select low pulse least width
// - fall to other rise least interval
// - deselect before retention, recover one write cycle time
`timescale 1ns/100ps
`default_nettype none
`include "asw_regs.svh"
module asw_ctrl (
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // user request
  input  wire logic                    wr_req_i,
  input  wire logic [`ASW_ADDR_W-1:0]  wr_addr_i,
  input  wire logic [`ASW_DATA_W-1:0]  wr_data_i,
  input  wire logic                    slow_grade_i,
  output var  logic                    busy_o,
  output var  logic                    done_o,
  // retention control
  input  wire logic                    retain_req_i,
  input  wire logic                    supply_ok_i,
  output var  logic                    retain_ready_o,
  // memory pins
  output var  logic [`ASW_ADDR_W-1:0]  location_inputs_o,
  output var  logic                    select_n_o,
  output var  logic                    strobe_n_o,
  output var  logic                    out_enable_n_o,
  output var  logic [`ASW_DATA_W-1:0]  shared_data_pins_o,
  output var  logic                    shared_data_pins_oe_n_o
);
  asw_pkg::asw_state_t state_ff;
  logic [`ASW_CNT_W-1:0] cnt_ff;
  logic                  grade_ff;
  logic                  supply_ok_s;

  function automatic logic [`ASW_CNT_W-1:0] cyc(input logic slow,
                                                  input int fast_ns,
                                                  input int slow_ns);
    int ns;
    ns = slow ? slow_ns : fast_ns;
    cyc = `ASW_CNT_W'(`ASW_CYC(ns));
  endfunction

  // strobe low covers the larger of width and data/address setup
  function automatic logic [`ASW_CNT_W-1:0] low_cyc(input logic slow);
    logic [`ASW_CNT_W-1:0] setup_c;
    logic [`ASW_CNT_W-1:0] width_c;
    logic [`ASW_CNT_W-1:0] data_c;
    setup_c = cyc(slow, `ASW_ADDR_SETUP_RISE_F_NS,
                  `ASW_ADDR_SETUP_RISE_S_NS);
    width_c = cyc(slow, `ASW_STROBE_LOW_WIDTH_F_NS,
                  `ASW_STROBE_LOW_WIDTH_S_NS);
    data_c  = cyc(slow, `ASW_DATA_SETUP_F_NS, `ASW_DATA_SETUP_S_NS);
    low_cyc = (setup_c > width_c) ? setup_c : width_c;
    if (data_c > low_cyc) begin
      low_cyc = data_c;
    end
  endfunction

  // the gap only pads what the other phases leave short of the cycle
  // time; worked in int so a short cycle cannot wrap the counter
  function automatic logic [`ASW_CNT_W-1:0] gap_cyc(input logic slow);
    int left;
    left = int'(cyc(slow, `ASW_CYCLE_TIME_F_NS, `ASW_CYCLE_TIME_S_NS)) -
           int'(low_cyc(slow)) - `ASW_FIXED_CYC;
    gap_cyc = (left > 0) ? `ASW_CNT_W'(left) : '0;
  endfunction

  asw_sync u_supply_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (supply_ok_i),
    .q_o   (supply_ok_s)
  );

  // state sequence; counts other than the gap's are minus one since each state spends cnt+1
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= asw_pkg::ASW_IDLE;
      cnt_ff   <= '0;
      grade_ff <= `ASW_GRADE_FAST;
    end else begin
      case (state_ff)
        asw_pkg::ASW_IDLE: begin
          if (retain_req_i) begin
            state_ff <= asw_pkg::ASW_RETAIN;
          end else if (wr_req_i) begin
            grade_ff <= slow_grade_i;
            state_ff <= asw_pkg::ASW_ADDR;
            cnt_ff   <= cyc(slow_grade_i, `ASW_ADDR_SETUP_FALL_NS,
                            `ASW_ADDR_SETUP_FALL_NS) - 1'b1;
          end
        end
        asw_pkg::ASW_ADDR: begin
          if (cnt_ff == '0) begin
            state_ff <= asw_pkg::ASW_STROBE;
            cnt_ff   <= low_cyc(grade_ff) - 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        asw_pkg::ASW_STROBE: begin
          if (cnt_ff == '0) begin
            state_ff <= asw_pkg::ASW_HOLD;
            cnt_ff   <= cyc(grade_ff, `ASW_HOLD_NS, `ASW_HOLD_NS) - 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        asw_pkg::ASW_HOLD: begin
          if (cnt_ff == '0) begin
            // pad to full cycle time before the next address change
            state_ff <= asw_pkg::ASW_GAP;
            cnt_ff   <= gap_cyc(grade_ff);
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        asw_pkg::ASW_GAP: begin
          if (cnt_ff == '0) begin
            state_ff <= asw_pkg::ASW_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        asw_pkg::ASW_RETAIN: begin
          if (!retain_req_i && supply_ok_s) begin
            state_ff <= asw_pkg::ASW_RECOVER;
            cnt_ff   <= cyc(grade_ff, `ASW_CYCLE_TIME_F_NS,
                            `ASW_CYCLE_TIME_S_NS) - 1'b1;
          end
        end
        asw_pkg::ASW_RECOVER: begin
          if (cnt_ff == '0) begin
            state_ff <= asw_pkg::ASW_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
        default: begin
          state_ff <= asw_pkg::ASW_IDLE;
        end
      endcase
    end
  end

  // address and data latch only when strobe is high, held through HOLD
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      location_inputs_o  <= '0;
      shared_data_pins_o <= '0;
    end else if (state_ff == asw_pkg::ASW_IDLE && wr_req_i &&
                 !retain_req_i) begin
      location_inputs_o  <= wr_addr_i;
      shared_data_pins_o <= wr_data_i;
    end
  end

  // strobes: select stays low for the write, strobe times the write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      select_n_o     <= 1'b1;
      strobe_n_o     <= 1'b1;
      out_enable_n_o <= 1'b1;
    end else begin
      // output enable held high so the memory never drives during writes
      out_enable_n_o <= 1'b1;
      select_n_o <= !(state_ff == asw_pkg::ASW_ADDR ||
                      state_ff == asw_pkg::ASW_STROBE ||
                      (state_ff == asw_pkg::ASW_IDLE && wr_req_i &&
                       !retain_req_i));
      strobe_n_o <= !((state_ff == asw_pkg::ASW_ADDR && cnt_ff == '0) ||
                      (state_ff == asw_pkg::ASW_STROBE &&
                       cnt_ff != '0));
    end
  end

  // data driven from the address phase through the hold phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shared_data_pins_oe_n_o <= 1'b1;
    end else begin
      shared_data_pins_oe_n_o <= !((state_ff == asw_pkg::ASW_IDLE &&
                                    wr_req_i && !retain_req_i) ||
                                   state_ff == asw_pkg::ASW_ADDR ||
                                   state_ff == asw_pkg::ASW_STROBE ||
                                   state_ff == asw_pkg::ASW_HOLD);
    end
  end

  // status outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o         <= 1'b0;
      done_o         <= 1'b0;
      retain_ready_o <= 1'b0;
    end else begin
      busy_o <= (state_ff != asw_pkg::ASW_IDLE) ||
                wr_req_i || retain_req_i;
      done_o <= (state_ff == asw_pkg::ASW_HOLD && cnt_ff == '0);
      retain_ready_o <= (state_ff == asw_pkg::ASW_RETAIN);
    end
  end
endmodule
`default_nettype wire

/* hw/asw_sync.sv */
// two-stage synchroniser for a pin level
// assumes the input is asynchronous to clk_i
`timescale 1ns/100ps
`default_nettype none
module asw_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // level in and out
  input  wire logic d_i,
  output var  logic q_o
);
  logic meta_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      q_o     <= 1'b0;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule
`default_nettype wire

/* include/asw_pkg.sv */
// types for the asynchronous static memory write controller
// assumes nothing beyond the header of constants
`default_nettype none
package asw_pkg;
  typedef enum logic [2:0] {
    ASW_IDLE,
    ASW_ADDR,
    ASW_STROBE,
    ASW_HOLD,
    ASW_GAP,
    ASW_RETAIN,
    ASW_RECOVER
  } asw_state_t;
endpackage
`default_nettype wire

/* include/asw_regs.svh */
// timing constants for the asynchronous static memory write controller
// assumes a 125 MHz controller clock (8 ns period)
`ifndef ASW_REGS_SVH
`define ASW_REGS_SVH

`define ASW_CLK_PERIOD_NS            8
`define ASW_ADDR_W                   15
`define ASW_DATA_W                   8
// speed grade select: 0 fast grade, 1 slow grade
`define ASW_GRADE_FAST               1'b0
// fast grade times in ns
`define ASW_CYCLE_TIME_F_NS          55
`define ASW_STROBE_LOW_WIDTH_F_NS    45
`define ASW_DATA_SETUP_F_NS          25
`define ASW_ADDR_SETUP_RISE_F_NS     45
`define ASW_STROBE_FALL_FLOAT_F_NS   20
// slow grade times in ns
`define ASW_CYCLE_TIME_S_NS          70
`define ASW_STROBE_LOW_WIDTH_S_NS    50
`define ASW_DATA_SETUP_S_NS          30
`define ASW_ADDR_SETUP_RISE_S_NS     60
`define ASW_STROBE_FALL_FLOAT_S_NS   25
// holds and setups of zero still take one cycle
`define ASW_ADDR_SETUP_FALL_NS       0
`define ASW_HOLD_NS                  0
`define ASW_DESELECT_RETENTION_NS    0
// least times round up to whole cycles
`define ASW_CYC(ns) ((((ns) + `ASW_CLK_PERIOD_NS - 1) / `ASW_CLK_PERIOD_NS) \
                     < 1 ? 1 : \
                     (((ns) + `ASW_CLK_PERIOD_NS - 1) / `ASW_CLK_PERIOD_NS))
`define ASW_CNT_W                    4
// address, hold, least gap and idle cycles inside every write cycle
`define ASW_FIXED_CYC                4

`endif

/* tb/asw_ctrl_props.sv */
// pin-timing checker for the memory write controller
// assumes a bind onto asw_ctrl and a single clock domain
`timescale 1ns/100ps
`default_nettype none
module asw_ctrl_props (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // status
  input wire logic        done_o,
  input wire logic        retain_ready_o,
  // memory pins
  input wire logic [14:0] location_inputs_o,
  input wire logic        select_n_o,
  input wire logic        strobe_n_o,
  input wire logic        out_enable_n_o,
  input wire logic [7:0]  shared_data_pins_o,
  input wire logic        shared_data_pins_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_start;
    $fell(select_n_o) ##1 $fell(strobe_n_o);
  endsequence
  a_addr_setup: assert property (
    s_start |-> $stable(location_inputs_o))
    else $error("address moved at strobe fall");
  a_addr_moves: assert property (
    $changed(location_inputs_o) |-> $past(strobe_n_o) && strobe_n_o)
    else $error("address moved in write");
  a_strobe_width: assert property (
    $fell(strobe_n_o) |-> !strobe_n_o[*6])
    else $error("strobe pulse short");
  a_select_width: assert property (
    $fell(select_n_o) |-> !select_n_o[*7])
    else $error("select pulse short");
  a_strobe_in_sel: assert property (
    !strobe_n_o |-> !select_n_o)
    else $error("strobe low unselected");
  a_data_steady: assert property (
    !strobe_n_o && !$fell(strobe_n_o) |-> $stable(shared_data_pins_o))
    else $error("data moved in write");
  a_data_hold: assert property (
    $rose(strobe_n_o) |->
    $stable(shared_data_pins_o) && !shared_data_pins_oe_n_o)
    else $error("data not held");
  a_no_contend: assert property (
    out_enable_n_o)
    else $error("output enable low");
  a_retain_desel: assert property (
    retain_ready_o |-> select_n_o && strobe_n_o)
    else $error("selected in retention");
  a_done_pulse: assert property (
    $rose(strobe_n_o) |-> ##[0:2] done_o)
    else $error("no done after write");
endmodule
bind asw_ctrl asw_ctrl_props i_props (.clk_i(clk_i), .rst_i(rst_i),
  .done_o(done_o), .retain_ready_o(retain_ready_o),
  .location_inputs_o(location_inputs_o), .select_n_o(select_n_o),
  .strobe_n_o(strobe_n_o), .out_enable_n_o(out_enable_n_o),
  .shared_data_pins_o(shared_data_pins_o),
  .shared_data_pins_oe_n_o(shared_data_pins_oe_n_o));
`default_nettype wire

/* tb/asw_sram_model.sv */
// behavioural byte-wide static memory on the controller pins
// assumes the bench resolves the shared data wire
`timescale 1ns/100ps
`default_nettype none
module asw_sram_model (
  // controls and location
  input  wire logic        sel_n_i,
  input  wire logic        str_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [14:0] addr_i,
  // shared data wire
  input  wire logic [7:0]  dq_i,
  output var  logic [7:0]  dq_o,
  output wire logic        dq_en_o
);
  logic [7:0] mem [0:32767];
  wire logic wr_on;
  assign wr_on = !sel_n_i && !str_n_i;
  always @(negedge wr_on) mem[addr_i] = dq_i;
  assign dq_o = mem[addr_i];
  // floats faster than it drives again, so no overlap with a writer
  assign #(6, 5) dq_en_o = !sel_n_i && !oe_n_i && str_n_i;
  // the shorter float delay above
endmodule
`default_nettype wire

/* tb/async_sram_write_cycle_bench.sv */
// self-checking bench for the memory write controller
// assumes the memory model on the pins and a 125 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "asw_regs.svh"
module async_sram_write_cycle_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, slow = 1'b0;
  logic retain = 1'b0, sup_ok = 1'b1;
  logic [14:0] addr = 15'h0000, loc;
  logic [7:0] data = 8'h00, dq_o, dq, dq_hold = 8'h00, m_q;
  logic busy, done, rdy, sel_n, str_n, oe_n, dq_oe_n;
  wire logic m_en;
  int error_cnt = 0, total_checks = 0, cyc = 0, wrun = 0, wlast = 0;
  always #4 clk_i = ~clk_i;
  asw_ctrl i_asw_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wr_req_i(req),
    .wr_addr_i(addr), .wr_data_i(data), .slow_grade_i(slow),
    .busy_o(busy), .done_o(done), .retain_req_i(retain),
    .supply_ok_i(sup_ok), .retain_ready_o(rdy), .location_inputs_o(loc),
    .select_n_o(sel_n), .strobe_n_o(str_n), .out_enable_n_o(oe_n),
    .shared_data_pins_o(dq_o), .shared_data_pins_oe_n_o(dq_oe_n));
  asw_sram_model i_asw_sram_model (.sel_n_i(sel_n), .str_n_i(str_n),
    .oe_n_i(oe_n), .addr_i(loc), .dq_i(dq), .dq_o(m_q), .dq_en_o(m_en));
  // a released wire shows the inverse of its last value
  always @* dq = !dq_oe_n ? dq_o : (m_en ? m_q : ~dq_hold);
  always @(posedge clk_i) begin
    if (!dq_oe_n) dq_hold <= dq_o;
    if (!str_n) wrun <= wrun + 1;
    else if (wrun != 0) begin
      wlast <= wrun;
      wrun <= 0;
    end
    if (!rst_i) chk({7'h00, !dq_oe_n && m_en}, 8'h00);
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // requests are only taken in idle, so every scenario starts there
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 40) begin @(posedge clk_i); #1; n++; end
    chk({7'h00, n < 40}, 8'h01);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 40) begin @(posedge clk_i); #1; n++; end
    chk({7'h00, n < 40}, 8'h01);
    @(posedge clk_i); #1;
    chk({7'h00, done}, 8'h00);
  endtask
  task automatic t_write(input logic s, input logic [14:0] a,
                         input logic [7:0] d, input int w);
    wait_idle();
    slow = s; addr = a; data = d; req = 1'b1;
    @(posedge clk_i); #1;
    req = 1'b0;
    chk({7'h00, busy}, 8'h01);
    wait_done();
    chk(8'(wlast), 8'(w));
    chk(i_asw_sram_model.mem[a], d);
  endtask
  task automatic t_refuse();
    wait_idle();
    addr = 15'h0012; data = 8'hc3; req = 1'b1;
    @(posedge clk_i); #1;
    addr = 15'h0000; data = 8'hff;
    @(posedge clk_i); #1;
    req = 1'b0;
    wait_done();
    chk(i_asw_sram_model.mem[15'h0000], 8'h5a);
    chk(i_asw_sram_model.mem[15'h0012], 8'hc3);
  endtask
  // the last write ran at the slow grade, so recovery is its cycle time
  task automatic t_retain();
    int n;
    int rec;
    rec = `ASW_CYC(`ASW_CYCLE_TIME_S_NS);
    wait_idle();
    retain = 1'b1; req = 1'b1; addr = 15'h7fff; data = 8'h77;
    repeat (3) @(posedge clk_i); #1;
    chk({6'h00, rdy, sel_n}, 8'h03);
    sup_ok = 1'b0;
    repeat (3) @(posedge clk_i); #1;
    retain = 1'b0; sup_ok = 1'b1;
    n = 0;
    while (sel_n === 1'b1 && n < 40) begin @(posedge clk_i); #1; n++; end
    chk({7'h00, n >= rec && n < 40}, 8'h01);
    req = 1'b0;
    wait_done();
    chk(i_asw_sram_model.mem[15'h7fff], 8'h77);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_write(1'b0, 15'h0000, 8'h5a, 6);
    t_write(1'b0, 15'h7fff, 8'ha5, 6);
    t_write(1'b1, 15'h1234, 8'h3c, 8);
    t_refuse();
    t_retain();
    complete_run();
  end
endmodule
`default_nettype wire
